// ### common/mdx_pkg.sv
// What this block does
// - SysEx bank/program accepted on any channel
// - SysEx program change ignores program-receive disable
// - Bank select latches; applies at next program change
// - Bank change switches part bank at once
// - Part commands: header, 72, part 00..0F
// - Multi change opcode 69, part 00; F0..F7
// - Edit-buffer routing: dumps overwrite edit buffer, show name
// - Forced bank routing stores dumps into that bank
// - Verify routing compares, flags errors, never writes
// - Expression CC11 defaults and resets to 127
// - Update: count blocks, abort on error, flag failure
// - Update staged and checked before burn command
// - Burn takes about 30 s, then self reset
package mdx_pkg;
    localparam logic [7:0] MDX_SOX        = 8'hf0;
    localparam logic [7:0] MDX_EOX        = 8'hf7;
    localparam logic [7:0] MDX_PART_TAG   = 8'h72;
    localparam logic [7:0] MDX_OP_BSEL    = 8'h1f;
    localparam logic [7:0] MDX_OP_BCHG    = 8'h20;
    localparam logic [7:0] MDX_OP_PCHG    = 8'h21;
    localparam logic [7:0] MDX_OP_MULTI   = 8'h69;
    localparam logic [7:0] MDX_MAX_PART   = 8'h0f;
    localparam logic [7:0] MDX_CC_EXPR    = 8'h0b;
    localparam logic [6:0] MDX_EXPR_RESET = 7'h7f;
    localparam logic [7:0] MDX_CC_STATUS  = 8'hb0;
    localparam int         MDX_HDR_LEN    = 5;
    // Dump routing encodings
    localparam logic [1:0] MDX_ROUTE_NORMAL = 2'h0;
    localparam logic [1:0] MDX_ROUTE_EDIT   = 2'h1;
    localparam logic [1:0] MDX_ROUTE_FORCE  = 2'h2;
    localparam logic [1:0] MDX_ROUTE_VERIFY = 2'h3;
    // Burn time
    localparam longint     MDX_BURN_S      = 30;
    localparam longint     MDX_CLK_HZ      = 10000000;
    localparam longint     MDX_BURN_CYCLES = MDX_BURN_S * MDX_CLK_HZ;
    localparam logic [2:0] MDX_RST_BANK    = 3'h0;
    localparam logic [6:0] MDX_RST_PROG    = 7'h00;
    typedef enum logic [3:0] {
        MDX_IDLE, MDX_HDR, MDX_TAG, MDX_PART, MDX_OP, MDX_VAL, MDX_END, MDX_SKIP
    } mdx_parse_e;
    typedef enum logic [1:0] {MDX_OS_IDLE, MDX_OS_RX, MDX_OS_READY, MDX_OS_BURN} mdx_os_e;
endpackage

// ### rtl/mdx_receiver.sv
`timescale 1ns/1ps
module mdx_receiver
    import mdx_pkg::*;
#(
    parameter longint BURN_CYCLES = MDX_BURN_CYCLES,
    parameter logic [7:0] ID0 = 8'h11, // Identity bytes: arbitrary values
    parameter logic [7:0] ID1 = 8'h22,
    parameter logic [7:0] ID2 = 8'h33,
    parameter logic [7:0] ID3 = 8'h44,
    parameter logic [7:0] ID4 = 8'h55
) (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       rxValid,        // One byte from the MIDI UART
    input  wire logic [7:0] rxByte,
    input  wire logic       pgmRxDisable,   // Not read in this block; SysEx program changes ignore it
    input  wire logic [1:0] dumpRoute,
    input  wire logic       forceSecondBank,
    input  wire logic       dumpValid,      // Decoded dump byte stream
    input  wire logic [7:0] dumpByte,
    input  wire logic       dumpLast,
    input  wire logic [7:0] memByte,        // Stored byte at current compare address
    input  wire logic       ctrlReset,
    input  wire logic       osBlockDone,
    input  wire logic       osBlockErr,
    input  wire logic       storeCmd,
    input  wire logic       retryCmd,
    output logic            sxStrobe_ff,
    output logic [3:0]      sxPart_ff,
    output logic [2:0]      sxBank_ff,
    output logic [6:0]      sxProg_ff,
    output logic            sxMulti_ff,
    output logic [6:0]      expression_ff,
    output logic            dumpWrEdit_ff,
    output logic            dumpWrBank_ff,
    output logic            dumpBankSel_ff,
    output logic [7:0]      dumpData_ff,
    output logic            showName_ff,
    output logic            dumpActive_ff,
    output logic            verifyErr_ff,
    output logic [15:0]     osBlockCount_ff,
    output logic            reception_error_indication_ff,
    output logic            stageWr_ff,
    output logic            flashBurn_ff,
    output logic            selfReset_ff
);
    // Elaboration check: a burn of zero cycles would never reach the
    // self reset, so the counter needs at least one cycle to run
    if (BURN_CYCLES < 1) begin : g_bad_burn
        $error("BURN_CYCLES must be positive");
    end

    // Overview of the byte path:
    // - Every MIDI byte arrives as a one-cycle rxValid pulse
    // - A start byte always restarts the header match from position 0
    // - The frame is fully checked before anything is changed
    // - Only the closing end byte commits the command
    // - Frames that fail a check before the end position fall into skip until the end byte; a wrong end byte drops to idle
    // Side paths:
    // - The controller parser watches the same byte stream
    // - Dump routing and the update sequencer have their own inputs

    // Parser state
    mdx_parse_e parse_ff, nxt_parse;
    logic [2:0] hdrIdx_ff;
    logic [3:0] partIdx_ff;
    logic [7:0] opcode_ff;
    logic [6:0] value_ff;
    logic [2:0] pendBank_ff [16];
    logic [2:0] curBank_ff [16];
    logic       ccState_ff, ccExpr_ff;

    // Header byte expected at each position
    // Positions past the last identity byte reuse the final one; the
    // parse leaves the header state before it could look there
    wire logic [7:0] hdrExp = (hdrIdx_ff == 3'h0) ? ID0 : (hdrIdx_ff == 3'h1) ? ID1 :
                              (hdrIdx_ff == 3'h2) ? ID2 : (hdrIdx_ff == 3'h3) ? ID3 : ID4;
    wire logic hdrLast = (hdrIdx_ff == 3'(MDX_HDR_LEN - 1));
    wire logic opKnown = (rxByte == MDX_OP_BSEL) || (rxByte == MDX_OP_BCHG) ||
                         (rxByte == MDX_OP_PCHG) || (rxByte == MDX_OP_MULTI);
    wire logic opMultiBad = (rxByte == MDX_OP_MULTI) && (partIdx_ff != 4'h0);
    wire logic isData = ~rxByte[7];
    // Command executes only at the closing F7, so a truncated frame changes nothing
    wire logic execCmd = rxValid && (parse_ff == MDX_END) && (rxByte == MDX_EOX);

    // Byte-serial parse; anything unexpected drops to skip, or to idle in place of the end byte, without effect
    // Trade-off: one byte per state keeps the decode small, at the cost
    // of holding the whole frame until its end byte before acting
    always_comb begin
        nxt_parse = parse_ff;
        if (rxValid) begin
            if (rxByte == MDX_SOX) nxt_parse = MDX_HDR;
            else case (parse_ff)
                MDX_IDLE: nxt_parse = MDX_IDLE;
                MDX_HDR:  nxt_parse = (rxByte != hdrExp) ? MDX_SKIP :
                                      hdrLast ? MDX_TAG : MDX_HDR;
                MDX_TAG:  nxt_parse = (rxByte == MDX_PART_TAG) ? MDX_PART : MDX_SKIP;
                MDX_PART: nxt_parse = (rxByte <= MDX_MAX_PART) ? MDX_OP : MDX_SKIP;
                MDX_OP:   nxt_parse = (opKnown && !opMultiBad) ? MDX_VAL : MDX_SKIP;
                MDX_VAL:  nxt_parse = isData ? MDX_END : MDX_SKIP;
                MDX_END:  nxt_parse = MDX_IDLE;
                MDX_SKIP: nxt_parse = (rxByte == MDX_EOX) ? MDX_IDLE : MDX_SKIP;
                default:  nxt_parse = MDX_IDLE;
            endcase
        end
    end

    // Frame field capture
    // Part, opcode and value are captured as they pass; a later frame
    // overwrites them before its own end byte can commit anything
    // A start byte inside the header must restart the position count,
    // otherwise a resent frame would be matched one byte out of step
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            parse_ff   <= MDX_IDLE;
            hdrIdx_ff  <= 3'h0;
            partIdx_ff <= 4'h0;
            opcode_ff  <= 8'h00;
            value_ff   <= 7'h00;
        end else begin
            parse_ff <= nxt_parse;
            if (rxValid) begin
                hdrIdx_ff <= (parse_ff == MDX_HDR && rxByte != MDX_SOX) ?
                             hdrIdx_ff + 3'h1 : 3'h0;
                if (parse_ff == MDX_PART) partIdx_ff <= rxByte[3:0];
                if (parse_ff == MDX_OP) opcode_ff <= rxByte;
                if (parse_ff == MDX_VAL) value_ff <= rxByte[6:0];
            end
        end
    end

    // Command decode
    // Each decode is true for exactly one cycle, the one taking the end byte
    // Bank command effects; channel number never consulted
    wire logic doBsel  = execCmd && (opcode_ff == MDX_OP_BSEL);
    wire logic doBchg  = execCmd && (opcode_ff == MDX_OP_BCHG);
    // Program change not gated by pgmRxDisable
    wire logic doPchg  = execCmd && (opcode_ff == MDX_OP_PCHG);
    wire logic doMulti = execCmd && (opcode_ff == MDX_OP_MULTI);

    // Per-part bank storage
    // Pending bank is what the next program change will apply;
    // current bank is what the part plays from right now
    // A bank change sets both so a later program change keeps it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) begin
                pendBank_ff[i] <= MDX_RST_BANK;
                curBank_ff[i]  <= MDX_RST_BANK;
            end
        end else begin
            if (doBsel) pendBank_ff[partIdx_ff] <= value_ff[2:0];
            if (doBchg) begin
                curBank_ff[partIdx_ff]  <= value_ff[2:0];
                pendBank_ff[partIdx_ff] <= value_ff[2:0];
            end
            if (doPchg) curBank_ff[partIdx_ff] <= pendBank_ff[partIdx_ff];
        end
    end

    // Output strobe for the voice manager
    // Bank select alone gives no strobe: nothing changes audibly yet
    // Fields hold their last value between strobes
    wire logic       anyExec = doBchg || doPchg || doMulti;
    wire logic [2:0] outBank = doBchg ? value_ff[2:0] : pendBank_ff[partIdx_ff];
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sxStrobe_ff <= 1'b0;
            sxPart_ff   <= 4'h0;
            sxBank_ff   <= MDX_RST_BANK;
            sxProg_ff   <= MDX_RST_PROG;
            sxMulti_ff  <= 1'b0;
        end else begin
            sxStrobe_ff <= anyExec;
            if (anyExec) begin
                sxPart_ff  <= partIdx_ff;
                sxBank_ff  <= outBank;
                sxMulti_ff <= doMulti;
                if (!doBchg) sxProg_ff <= value_ff;
            end
        end
    end

    // Expression controller: status B0..BF any channel, then 0B, then value
    // Running status: after an expression (0B) value byte another number byte may follow
    // without a repeated status byte
    // Limitation: any other status byte, real-time ones included,
    // ends running status
    wire logic ccStatus = rxValid && (rxByte[7:4] == MDX_CC_STATUS[7:4]);
    wire logic ccNum    = rxValid && ccState_ff && isData;
    wire logic ccVal    = rxValid && ccExpr_ff && isData;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ccState_ff    <= 1'b0;
            ccExpr_ff     <= 1'b0;
            expression_ff <= MDX_EXPR_RESET;
        end else begin
            if (rxValid && rxByte[7]) ccState_ff <= ccStatus;
            else if (ccNum) ccState_ff <= 1'b0;
            else if (ccVal) ccState_ff <= 1'b1; // Running status
            ccExpr_ff <= ccNum ? (rxByte == MDX_CC_EXPR) : (rxValid ? 1'b0 : ccExpr_ff);
            // Reset priority: a controller reset overrides same-cycle value
            if (ctrlReset) expression_ff <= MDX_EXPR_RESET;
            else if (ccVal) expression_ff <= rxByte[6:0];
        end
    end

    // Dump routing; verify never raises a write strobe
    // Normal routing writes to the bank that dumpBankSel_ff last held;
    // forced routing writes to the bank chosen by forceSecondBank
    // Verify only compares, so stored sounds stay untouched
    wire logic inEdit   = dumpRoute == MDX_ROUTE_EDIT;
    wire logic inForce  = dumpRoute == MDX_ROUTE_FORCE;
    wire logic inVerify = dumpRoute == MDX_ROUTE_VERIFY;
    wire logic mismatch = dumpValid && inVerify && (dumpByte != memByte);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dumpWrEdit_ff  <= 1'b0;
            dumpWrBank_ff  <= 1'b0;
            dumpBankSel_ff <= 1'b0;
            dumpData_ff    <= 8'h00;
            showName_ff    <= 1'b0;
            dumpActive_ff  <= 1'b0;
            verifyErr_ff   <= 1'b0;
        end else begin
            dumpWrEdit_ff  <= dumpValid && inEdit;
            dumpWrBank_ff  <= dumpValid && !inEdit && !inVerify;
            dumpBankSel_ff <= inForce ? forceSecondBank : dumpBankSel_ff;
            dumpData_ff    <= dumpValid ? dumpByte : dumpData_ff;
            showName_ff    <= dumpValid && dumpLast && inEdit;
            dumpActive_ff  <= dumpValid && inVerify;
            // Error is sticky; the last byte of a non-verify dump clears it, set wins
            if (mismatch) verifyErr_ff <= 1'b1;
            else if (dumpValid && dumpLast && !inVerify) verifyErr_ff <= 1'b0;
        end
    end

    // OS update: stage, count, abort on error, burn on store
    // Good blocks go to the staging buffer only; the flash is touched
    // after two store commands: one to leave receive, one to burn
    // An errored block leaves the old firmware alone and waits for retry
    // The burn counter is wide so the full burn time fits in cycles
    mdx_os_e os_ff;
    longint  burnCnt_ff;
    wire logic osGoodBlk = (os_ff == MDX_OS_RX) && osBlockDone && !osBlockErr;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            os_ff                         <= MDX_OS_RX;
            osBlockCount_ff               <= 16'h0000;
            reception_error_indication_ff <= 1'b0;
            stageWr_ff                    <= 1'b0;
            flashBurn_ff                  <= 1'b0;
            selfReset_ff                  <= 1'b0;
            burnCnt_ff                    <= 64'sh0;
        end else begin
            stageWr_ff   <= osGoodBlk;
            selfReset_ff <= 1'b0;
            case (os_ff)
                MDX_OS_IDLE: if (retryCmd) begin
                    os_ff                         <= MDX_OS_RX;
                    osBlockCount_ff               <= 16'h0000;
                    reception_error_indication_ff <= 1'b0;
                end
                MDX_OS_RX: begin
                    if (osBlockDone && osBlockErr) begin
                        os_ff                         <= MDX_OS_IDLE;
                        reception_error_indication_ff <= 1'b1;
                    end else if (osGoodBlk) begin
                        osBlockCount_ff <= osBlockCount_ff + 16'h0001;
                    end else if (storeCmd && osBlockCount_ff != 16'h0000) begin
                        os_ff <= MDX_OS_READY;
                    end
                end
                MDX_OS_READY: if (storeCmd) begin
                    os_ff        <= MDX_OS_BURN;
                    flashBurn_ff <= 1'b1;
                    burnCnt_ff   <= BURN_CYCLES - 1;
                end
                MDX_OS_BURN: begin
                    if (burnCnt_ff == 0) begin
                        flashBurn_ff <= 1'b0;
                        selfReset_ff <= 1'b1;
                        os_ff        <= MDX_OS_RX;
                        osBlockCount_ff <= 16'h0000;
                    end else begin
                        burnCnt_ff <= burnCnt_ff - 1;
                    end
                end
                default: os_ff <= MDX_OS_IDLE;
            endcase
        end
    end
endmodule

// ### verif/mdx_midi_sender.sv
`timescale 1ns/1ps
// Far-side sequencer: sends whole SysEx frames and controller bytes
module mdx_midi_sender
    import mdx_pkg::*;
#(
    parameter logic [7:0] ID0 = 8'h11, // Identity bytes: arbitrary values
    parameter logic [7:0] ID1 = 8'h22,
    parameter logic [7:0] ID2 = 8'h33,
    parameter logic [7:0] ID3 = 8'h44,
    parameter logic [7:0] ID4 = 8'h55
) (
    input  wire logic       ref_clk,
    output logic            rxValid,
    output logic [7:0]      rxByte
);
    initial begin
        rxValid = 1'b0;
        rxByte  = 8'h00;
    end
    // Idle data is inverted so a stale byte is never mistaken for a new one
    task automatic put(input logic [7:0] b, input int gap);
        @(negedge ref_clk);
        rxValid = 1'b1;
        rxByte  = b;
        @(negedge ref_clk);
        rxValid = 1'b0;
        rxByte  = ~b;
        repeat (gap) @(negedge ref_clk);
    endtask
    // No timing clock bytes are interleaved; slow mode spaces bytes out
    task automatic frame(input logic [7:0] p, op, v, input logic bad, slow);
        int g;
        g = slow ? 3 : 0;
        put(MDX_SOX, g);
        put(ID0, g);
        put(bad ? ~ID1 : ID1, g);
        put(ID2, g);
        put(ID3, g);
        put(ID4, g);
        put(MDX_PART_TAG, g);
        put(p, g);
        put(op, g);
        put(v, g);
        put(MDX_EOX, g);
    endtask
endmodule

// ### verif/mdx_receiver_asserts.sv
`timescale 1ns/1ps
// Port-level timing checks of the receiver
module mdx_receiver_asserts
    import mdx_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       rxValid,
    input wire logic [7:0] rxByte,
    input wire logic [1:0] dumpRoute,
    input wire logic       forceSecondBank,
    input wire logic       dumpValid,
    input wire logic [7:0] dumpByte,
    input wire logic [7:0] memByte,
    input wire logic       ctrlReset,
    input wire logic       osBlockDone,
    input wire logic       osBlockErr,
    input wire logic       storeCmd,
    input wire logic       sxStrobe_ff,
    input wire logic       sxMulti_ff,
    input wire logic [6:0] expression_ff,
    input wire logic       dumpWrEdit_ff,
    input wire logic       dumpWrBank_ff,
    input wire logic       dumpBankSel_ff,
    input wire logic [7:0] dumpData_ff,
    input wire logic       dumpActive_ff,
    input wire logic       verifyErr_ff,
    input wire logic       reception_error_indication_ff,
    input wire logic       stageWr_ff,
    input wire logic       flashBurn_ff,
    input wire logic       selfReset_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Frame end seen on the byte stream
    wire eoxTaken = rxValid && (rxByte == MDX_EOX);
    wire isVerify = dumpValid && (dumpRoute == MDX_ROUTE_VERIFY);
    a_strobe_end: assert property (sxStrobe_ff |-> $past(eoxTaken) || $past(eoxTaken, 2))
        else $error("strobe without a frame end");
    a_strobe_pulse: assert property (sxStrobe_ff |=> !sxStrobe_ff)
        else $error("strobe longer than one cycle");
    a_expr_reset: assert property (ctrlReset |=> expression_ff == MDX_EXPR_RESET)
        else $error("expression not restored");
    a_edit_write: assert property (dumpValid && dumpRoute == MDX_ROUTE_EDIT |=>
        dumpWrEdit_ff && !dumpWrBank_ff && dumpData_ff == $past(dumpByte))
        else $error("edit buffer write wrong");
    a_forced_bank: assert property (dumpValid && dumpRoute == MDX_ROUTE_FORCE |=>
        dumpWrBank_ff && dumpBankSel_ff == $past(forceSecondBank))
        else $error("forced bank write wrong");
    a_verify_safe: assert property (isVerify |=> dumpActive_ff && !dumpWrEdit_ff && !dumpWrBank_ff)
        else $error("verify wrote memory");
    a_verify_err: assert property (isVerify && dumpByte != memByte |=> verifyErr_ff)
        else $error("verify mismatch missed");
    a_fail_flag: assert property (osBlockDone && osBlockErr && !flashBurn_ff |=>
        reception_error_indication_ff)
        else $error("block error not flagged");
    a_fail_quiet: assert property (reception_error_indication_ff |-> !stageWr_ff && !flashBurn_ff)
        else $error("staging or burn after failure");
    a_burn_cmd: assert property ($rose(flashBurn_ff) |-> $past(storeCmd))
        else $error("burn without store command");
    a_reset_after: assert property ($rose(selfReset_ff) |-> $past(flashBurn_ff) || $past(flashBurn_ff, 2))
        else $error("self reset without burn");
    c_multi: cover property (sxStrobe_ff && sxMulti_ff);
    c_verr: cover property ($rose(verifyErr_ff));
    c_boot: cover property (selfReset_ff);
endmodule
bind mdx_receiver mdx_receiver_asserts mdx_receiver_asserts_inst (
    .ref_clk, .sys_rst, .rxValid, .rxByte, .dumpRoute, .forceSecondBank, .dumpValid, .dumpByte,
    .memByte, .ctrlReset, .osBlockDone, .osBlockErr, .storeCmd, .sxStrobe_ff, .sxMulti_ff,
    .expression_ff, .dumpWrEdit_ff, .dumpWrBank_ff, .dumpBankSel_ff, .dumpData_ff, .dumpActive_ff,
    .verifyErr_ff, .reception_error_indication_ff, .stageWr_ff, .flashBurn_ff, .selfReset_ff
);

// ### verif/mdx_receiver_test.sv
`timescale 1ns/1ps
module mdx_receiver_test;
    import mdx_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, rxValid, pgmRxDisable = 1'b1, forceSecondBank = 1'b0;
    logic dumpValid = 1'b0, dumpLast = 1'b0, ctrlReset = 1'b0, osBlockDone = 1'b0;
    logic osBlockErr = 1'b0, storeCmd = 1'b0, retryCmd = 1'b0;
    logic [7:0] rxByte, dumpByte = 8'h00, memByte = 8'h00, p, v, b;
    logic [1:0] dumpRoute = 2'h0;
    logic sxStrobe_ff, sxMulti_ff, dumpWrEdit_ff, dumpWrBank_ff, dumpBankSel_ff, showName_ff;
    logic dumpActive_ff, verifyErr_ff, reception_error_indication_ff, stageWr_ff;
    logic flashBurn_ff, selfReset_ff;
    logic [3:0] sxPart_ff;
    logic [2:0] sxBank_ff;
    logic [6:0] sxProg_ff, expression_ff;
    logic [7:0] dumpData_ff;
    logic [15:0] osBlockCount_ff;
    int mismatches = 0, checked = 0, cycles = 0, strobes = 0, wrs = 0, stages = 0, burnLen = 0;
    int names = 0;
    always #50 ref_clk = ~ref_clk;
    mdx_receiver #(.BURN_CYCLES(10)) mdx_receiver_inst (.ref_clk, .sys_rst, .rxValid, .rxByte,
        .pgmRxDisable, .dumpRoute, .forceSecondBank, .dumpValid, .dumpByte, .dumpLast, .memByte,
        .ctrlReset, .osBlockDone, .osBlockErr, .storeCmd, .retryCmd, .sxStrobe_ff, .sxPart_ff,
        .sxBank_ff, .sxProg_ff, .sxMulti_ff, .expression_ff, .dumpWrEdit_ff, .dumpWrBank_ff,
        .dumpBankSel_ff, .dumpData_ff, .showName_ff, .dumpActive_ff, .verifyErr_ff,
        .osBlockCount_ff, .reception_error_indication_ff, .stageWr_ff, .flashBurn_ff, .selfReset_ff);
    mdx_midi_sender mdx_midi_sender_inst (.ref_clk, .rxValid, .rxByte);
    // Event tallies; a hang is cut short by the cycle ceiling
    always @(posedge ref_clk) begin
        cycles++;
        strobes += int'(sxStrobe_ff === 1'b1);
        wrs += int'(dumpWrEdit_ff === 1'b1) + int'(dumpWrBank_ff === 1'b1);
        stages += int'(stageWr_ff === 1'b1);
        burnLen += int'(flashBurn_ff === 1'b1);
        names += int'(showName_ff === 1'b1);
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One frame, then the number of strobes it caused
    task automatic sx(input logic [7:0] pp, op, vv, input logic bad, input int exp);
        int n0;
        n0 = strobes;
        mdx_midi_sender_inst.frame(pp, op, vv, bad, 1'($urandom_range(1)));
        repeat (3) @(negedge ref_clk);
        check(16'(strobes - n0), 16'(exp));
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask
    // Four dump bytes; the byte at index bad disagrees with memory
    task automatic dump(input logic [1:0] r, input int bad);
        dumpRoute = r;
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            dumpValid = 1'b1;
            dumpByte = 8'($urandom);
            memByte = (i == bad) ? ~dumpByte : dumpByte;
            dumpLast = (i == 3);
        end
        @(negedge ref_clk);
        dumpValid = 1'b0;
        dumpLast = 1'b0;
        @(negedge ref_clk);
    endtask
    initial begin
        void'($urandom(22));
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(16'(expression_ff), 16'h7f);
        // Program changes arrive while channel program change is disabled
        for (int i = 0; i < 6; i++) begin
            p = (i == 0) ? 8'h0f : 8'($urandom_range(15));
            v = (i == 0) ? 8'h7f : 8'($urandom_range(127));
            b = 8'($urandom_range(7));
            sx(p, MDX_OP_BSEL, b, 1'b0, 0);
            sx(p, MDX_OP_PCHG, v, 1'b0, 1);
            check({1'b0, sxMulti_ff, sxPart_ff, sxBank_ff, sxProg_ff}, {2'h0, p[3:0], b[2:0], v[6:0]});
            b = 8'($urandom_range(7));
            sx(p, MDX_OP_BCHG, b, 1'b0, 1);
            check({12'h000, sxPart_ff, sxBank_ff}, {9'h000, p[3:0], b[2:0]});
            sx(8'h00, MDX_OP_MULTI, v, 1'b0, 1);
            check({8'h00, sxMulti_ff, sxProg_ff}, {8'h01, v[6:0]});
        end
        // Bad identity, part, value and multi part are all dropped
        for (int k = 0; k < 4; k++)
            sx((k == 1) ? 8'h10 : 8'h01, (k == 3) ? MDX_OP_MULTI : MDX_OP_PCHG,
               (k == 2) ? 8'h80 : 8'h05, k == 0, 0);
        check(16'(sxProg_ff), 16'(v[6:0]));
        $display("done: sysex");
        v = 8'($urandom_range(126));
        mdx_midi_sender_inst.put(MDX_CC_STATUS | 8'($urandom_range(15)), 0);
        mdx_midi_sender_inst.put(MDX_CC_EXPR, 0);
        mdx_midi_sender_inst.put(v, 0);
        @(negedge ref_clk);
        check(16'(expression_ff), 16'(v));
        pulse(ctrlReset);
        @(negedge ref_clk);
        check(16'(expression_ff), 16'h7f);
        $display("done: expression");
        dump(MDX_ROUTE_EDIT, 9);
        check(16'(names), 16'h1);
        check(16'(dumpData_ff), 16'(dumpByte));
        dump(MDX_ROUTE_FORCE, 9);
        forceSecondBank = 1'b1;
        dump(MDX_ROUTE_FORCE, 9);
        check({15'h0, dumpBankSel_ff}, 16'h1);
        check(16'(wrs), 16'd12);
        dump(MDX_ROUTE_VERIFY, 9);
        check(16'(verifyErr_ff), 16'h0);
        dump(MDX_ROUTE_VERIFY, 2);
        check({15'h0, verifyErr_ff}, 16'h1);
        check(16'(wrs), 16'd12);
        dump(MDX_ROUTE_NORMAL, 9);
        check(16'(verifyErr_ff), 16'h0);
        check(16'(wrs), 16'd16);
        $display("done: dumps");
        repeat (2) pulse(osBlockDone);
        check(osBlockCount_ff, 16'h2);
        @(negedge ref_clk);
        check(16'(stages), 16'h2);
        osBlockErr = 1'b1;
        pulse(osBlockDone);
        osBlockErr = 1'b0;
        check({15'h0, reception_error_indication_ff}, 16'h1);
        pulse(storeCmd);
        pulse(storeCmd);
        check(16'(burnLen), 16'h0);
        pulse(retryCmd);
        // Second reset in mid-run, then a clean upload and burn
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (3) pulse(osBlockDone);
        check(osBlockCount_ff, 16'h3);
        pulse(storeCmd);
        check(16'(burnLen), 16'h0);
        pulse(storeCmd);
        for (int n = 0; n < 50 && selfReset_ff !== 1'b1; n++)
            @(negedge ref_clk);
        check(16'(burnLen), 16'd10);
        $display("done: update");
        wrap_up();
    end
endmodule
